// [hw/dpio_top.sv]
// Overview of operation
// [RULE1] Direction bit 1 output, 0 input
// [RULE2] Output line follows its latch bit
// [RULE3] Select 0 with access bit reads A pins
// [RULE4] Port A read returns pin levels always
// [RULE5] Port B read: latch for outputs, pins else
// [RULE6] Port B input lines are not driven
// [RULE7] Selects plus access bit pick the register
// [RULE8] Write all six, read control and direction
// [RULE9] Control register steers the control lines
// [RULE10] Processor masks mixed port bits itself
// [RULE11] Access bit 1 latch, 0 direction
// [RULE12] Writes land after the phase clock falls
// [RULE13] Port data read clears both flags
// [RULE14] Reset clears registers, lines become inputs
`timescale 1ns/1ps
module dpio_top (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       bus_phase_clock,
    input  wire logic       chip_sel,
    input  wire logic       bus_read,
    input  wire logic       reg_select_high,
    input  wire logic       reg_select_low,
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic            data_oe_n,
    input  wire logic [7:0] port_a_lines_in,
    output logic      [7:0] port_a_lines_out,
    output logic      [7:0] port_a_lines_oe_n,
    input  wire logic [7:0] port_b_lines_in,
    output logic      [7:0] port_b_lines_out,
    output logic      [7:0] port_b_lines_oe_n,
    input  wire logic       port_a_ctrl_in,
    input  wire logic       port_b_ctrl_in,
    input  wire logic       port_a_ctrl_io_in,
    output logic            port_a_ctrl_io_out,
    output logic            port_a_ctrl_io_oe_n,
    input  wire logic       port_b_ctrl_io_in,
    output logic            port_b_ctrl_io_out,
    output logic            port_b_ctrl_io_oe_n
);
    function automatic dpio_pkg::dpio_sel_type dpio_decode(
        input logic [1:0] rs,
        input logic [1:0] acc
    );
        dpio_pkg::dpio_sel_type s;
        s.port = rs[1];
        if (rs[0]) begin
            s.kind = dpio_pkg::DPIO_CTRL;
        end else if (acc[rs[1]]) begin
            s.kind = dpio_pkg::DPIO_LATCH;
        end else begin
            s.kind = dpio_pkg::DPIO_DIR;
        end
        return s;
    endfunction

    dpio_pkg::dpio_bus_type bus_s1, bus_s2, hold;
    dpio_pkg::dpio_bus_type bus_pins;
    logic             phase_d;
    logic             hold_valid;
    logic [15:0]      lines_s1, lines_s2;
    logic [3:0]       cl_s1, cl_s2, cl_prev;
    logic [7:0]       out_latch [2];
    logic [7:0]       direction [2];
    logic [7:0]       control   [2];
    logic [7:0]       oe_n      [2];
    logic [7:0]       read_val  [2];
    logic [1:0]       cio_out, cio_oe_n, rd_hit, wr_hit, set_in, set_io;

    assign bus_pins = {bus_phase_clock, chip_sel, bus_read,
                       reg_select_high, reg_select_low, data_in};

    // Every pin but rstn passes two flip-flops before any logic looks at it
    always_ff @(posedge clk) begin
        bus_s1   <= bus_pins;
        bus_s2   <= bus_s1;
        lines_s1 <= {port_b_lines_in, port_a_lines_in};
        lines_s2 <= lines_s1;
        cl_s1    <= {port_b_ctrl_io_in, port_b_ctrl_in,
                     port_a_ctrl_io_in, port_a_ctrl_in};
        cl_s2    <= cl_s1;
        cl_prev  <= cl_s2;
        phase_d  <= bus_s2.phase;
    end

    wire       phase_fall = phase_d & ~bus_s2.phase;
    wire       access     = bus_s2.phase & bus_s2.sel;
    wire [1:0] acc_bits   = {control[1][dpio_pkg::DDR_ACC],
                             control[0][dpio_pkg::DDR_ACC]};
    wire dpio_pkg::dpio_sel_type live_sel = dpio_decode(bus_s2.rs, acc_bits);
    wire dpio_pkg::dpio_sel_type hold_sel = dpio_decode(hold.rs, acc_bits);
    wire commit = phase_fall & hold_valid; // see [RULE12]
    wire [7:0] live_val =
        (live_sel.kind == dpio_pkg::DPIO_LATCH) ? read_val[live_sel.port] :
        (live_sel.kind == dpio_pkg::DPIO_DIR)   ? direction[live_sel.port] :
        control[live_sel.port]; // see [RULE7] see [RULE8]

    // Bus access is caught while the phase clock is high
    always_ff @(posedge clk) begin
        if (!rstn) begin
            hold       <= '0;
            hold_valid <= 1'b0;
            data_out   <= dpio_pkg::REG_RESET;
            data_oe_n  <= 1'b1;
        end else begin
            if (access) begin
                hold       <= bus_s2; // see [RULE12]
                hold_valid <= 1'b1;
            end else if (phase_fall) begin
                hold_valid <= 1'b0;
            end
            data_oe_n <= ~(access & bus_s2.read);
            if (access & bus_s2.read) begin
                data_out <= live_val;
            end
        end
    end

    genvar p;
    generate
        for (p = 0; p < dpio_pkg::NPORT; p++) begin : g_port
            wire [7:0] pins   = lines_s2[p*8 +: 8];
            wire       hit    = commit & (hold_sel.port == p);
            wire       c_in   = cl_s2[p*2];
            wire       c_io   = cl_s2[p*2+1];
            wire       e_in   = control[p][dpio_pkg::IN_POL] ?
                                (c_in & ~cl_prev[p*2]) :
                                (~c_in & cl_prev[p*2]);
            wire       e_io   = control[p][dpio_pkg::IO_MODE] ?
                                (c_io & ~cl_prev[p*2+1]) :
                                (~c_io & cl_prev[p*2+1]);
            wire       is_out = control[p][dpio_pkg::IO_OUTPUT];
            wire       wr_l   = hit & ~hold.read &
                                (hold_sel.kind == dpio_pkg::DPIO_LATCH);
            wire       wr_d   = hit & ~hold.read &
                                (hold_sel.kind == dpio_pkg::DPIO_DIR);
            wire       wr_c   = hit & ~hold.read &
                                (hold_sel.kind == dpio_pkg::DPIO_CTRL);
            wire       trig   = (p == 0) ? rd_hit[p] : wr_hit[p];
            wire [7:0] ctl_nx = {control[p][7:6],
                                 hold.data[dpio_pkg::WR_BITS-1:0]};

            assign rd_hit[p] = hit & hold.read &
                               (hold_sel.kind == dpio_pkg::DPIO_LATCH);
            assign wr_hit[p] = wr_l;
            assign set_in[p] = e_in;
            assign set_io[p] = e_io & ~is_out;
            if (p == 0) begin : g_rda
                assign read_val[p] = pins; // see [RULE3] see [RULE4]
            end else begin : g_rdb
                assign read_val[p] = (out_latch[p] & direction[p]) |
                                     (pins & ~direction[p]); // see [RULE5]
            end

            always_ff @(posedge clk) begin
                if (!rstn) begin
                    out_latch[p] <= dpio_pkg::REG_RESET; // see [RULE14]
                    direction[p] <= dpio_pkg::REG_RESET;
                    control[p]   <= dpio_pkg::REG_RESET;
                    oe_n[p]      <= dpio_pkg::ALL_IN;
                    cio_out[p]   <= 1'b1;
                    cio_oe_n[p]  <= 1'b1;
                end else begin
                    if (wr_l) begin
                        out_latch[p] <= hold.data; // see [RULE11]
                    end
                    if (wr_d) begin
                        direction[p] <= hold.data; // see [RULE11]
                        oe_n[p]      <= ~hold.data; // see [RULE1] see [RULE6]
                    end
                    // Flag set wins over the read that clears it
                    control[p] <= {
                        (control[p][7] & ~rd_hit[p]) | set_in[p],
                        (control[p][6] & ~rd_hit[p]) | set_io[p],
                        wr_c ? ctl_nx[5:0] : control[p][5:0]
                    }; // see [RULE13] see [RULE8]
                    cio_oe_n[p] <= ~is_out; // see [RULE9]
                    if (!is_out) begin
                        cio_out[p] <= 1'b1;
                    end else if (control[p][dpio_pkg::IO_MODE]) begin
                        cio_out[p] <= control[p][dpio_pkg::IO_LEVEL];
                    end else if (trig) begin
                        cio_out[p] <= 1'b0; // see [RULE9]
                    end else if (control[p][dpio_pkg::IO_LEVEL]) begin
                        if (phase_fall) begin
                            cio_out[p] <= 1'b1;
                        end
                    end else if (e_in) begin
                        cio_out[p] <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    assign port_a_lines_out    = out_latch[0]; // see [RULE2]
    assign port_b_lines_out    = out_latch[1];
    assign port_a_lines_oe_n   = oe_n[0];
    assign port_b_lines_oe_n   = oe_n[1];
    assign port_a_ctrl_io_out  = cio_out[0];
    assign port_a_ctrl_io_oe_n = cio_oe_n[0];
    assign port_b_ctrl_io_out  = cio_out[1];
    assign port_b_ctrl_io_oe_n = cio_oe_n[1];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    dir_drive_a : assert property ( // see [RULE1]
        port_a_lines_oe_n == ~direction[0])
        else $error("port A enables disagree with direction");
    latch_drive_a : assert property ( // see [RULE2]
        wr_hit[0] |=> port_a_lines_out == $past(hold.data))
        else $error("port A lines do not follow latch");
    wire [7:0] pins_a_w = lines_s2[7:0];
    read_pins_a : assert property ( // see [RULE3]
        access && bus_s2.read && bus_s2.rs == dpio_pkg::RS_PORT_A
        && control[0][dpio_pkg::DDR_ACC] |=> data_out == $past(pins_a_w)
        && !data_oe_n)
        else $error("port A read did not return pin levels");
    read_mix_b : assert property ( // see [RULE5]
        access && bus_s2.read && bus_s2.rs == dpio_pkg::RS_PORT_B
        && control[1][dpio_pkg::DDR_ACC] |=> data_out ==
        (($past(out_latch[1]) & $past(direction[1])) |
         ($past(lines_s2[15:8]) & ~$past(direction[1]))))
        else $error("port B read mix wrong");
    hiz_inputs_b : assert property ( // see [RULE6]
        (port_b_lines_oe_n | direction[1]) == dpio_pkg::ALL_IN)
        else $error("port B input line is driven");
    write_late_a : assert property ( // see [RULE12]
        $changed(out_latch[0]) |-> $past(phase_fall))
        else $error("latch changed outside phase fall");
    access_bit_a : assert property ( // see [RULE11]
        $changed(direction[0]) |-> !$past(control[0][dpio_pkg::DDR_ACC]))
        else $error("direction written with access bit set");
    read_clear_a : assert property ( // see [RULE13]
        rd_hit[0] && !set_in[0] && !set_io[0] |=> control[0][7:6] == 2'h0)
        else $error("port A flags not cleared by read");
    reset_clear_a : assert property ( // see [RULE14]
        @(posedge clk) disable iff (1'b0)
        !rstn |=> direction[0] == dpio_pkg::REG_RESET &&
        port_b_lines_oe_n == dpio_pkg::ALL_IN && control[1] == 8'h00)
        else $error("reset did not clear registers");
    manual_io_a : assert property ( // see [RULE9]
        control[0][5:4] == 2'h3 |=> port_a_ctrl_io_out ==
        $past(control[0][dpio_pkg::IO_LEVEL]) && !port_a_ctrl_io_oe_n)
        else $error("manual control output wrong");

    port_a_read_c  : cover property (rd_hit[0]);
    port_b_write_c : cover property (wr_hit[1]);
    flag_set_c     : cover property (set_in[0] ##[1:40] rd_hit[0]);
    ctrl_write_c   : cover property (commit && hold.rs == dpio_pkg::RS_CTRL_B);
endmodule

// [hw/dpio_pkg.sv]
package dpio_pkg;
    localparam int PORT_W = 8;
    localparam int NPORT  = 2;
    // Control register bit positions
    localparam int FLAG_IN   = 7;
    localparam int FLAG_IO   = 6;
    localparam int IO_OUTPUT = 5;
    localparam int IO_MODE   = 4;
    localparam int IO_LEVEL  = 3;
    localparam int DDR_ACC   = 2;
    localparam int IN_POL    = 1;
    localparam int WR_BITS   = 6;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] ALL_IN    = 8'hff;
    localparam logic [1:0] RS_PORT_A = 2'h0;
    localparam logic [1:0] RS_CTRL_A = 2'h1;
    localparam logic [1:0] RS_PORT_B = 2'h2;
    localparam logic [1:0] RS_CTRL_B = 2'h3;

    typedef enum logic [2:0] {
        DPIO_LATCH = 3'b001,
        DPIO_DIR   = 3'b010,
        DPIO_CTRL  = 3'b100
    } dpio_kind_type;

    typedef struct packed {
        logic          port;
        dpio_kind_type kind;
    } dpio_sel_type;

    typedef struct packed {
        logic       phase;
        logic       sel;
        logic       read;
        logic [1:0] rs;
        logic [7:0] data;
    } dpio_bus_type;
endpackage

// [bench/dpio_periph_model.sv]
`timescale 1ns/1ps
module dpio_periph_model (
    input  wire logic [7:0] a_out,
    input  wire logic [7:0] a_oe_n,
    input  wire logic [7:0] b_out,
    input  wire logic [7:0] b_oe_n,
    input  wire logic [7:0] ext_val,
    input  wire logic [7:0] clamp_low,
    input  wire logic       cio_a_out,
    input  wire logic       cio_a_oe_n,
    input  wire logic       cio_b_out,
    input  wire logic       cio_b_oe_n,
    output logic      [7:0] a_pins,
    output logic      [7:0] b_pins,
    output logic            cio_a_pins,
    output logic            cio_b_pins
);
    // Peripheral drives every undriven line; clamp pulls driven lines low
    assign a_pins = (~a_oe_n & a_out & ~clamp_low) | (a_oe_n & ext_val);
    assign b_pins = (~b_oe_n & b_out & ~clamp_low) | (b_oe_n & ext_val);
    // Released control lines sit high on their pull-ups
    assign cio_a_pins = cio_a_oe_n ? 1'b1 : cio_a_out;
    assign cio_b_pins = cio_b_oe_n ? 1'b1 : cio_b_out;
endmodule

// [bench/dual_port_parallel_io_tb_top.sv]
`timescale 1ns/1ps
module dual_port_parallel_io_tb_top;
    logic                  clk = 1'b0;
    logic                  rstn = 1'b0;
    logic                  sel = 1'b0;
    dpio_pkg::dpio_bus_type bus = '0;
    logic                  a_ctl = 1'b0;
    logic                  b_ctl = 1'b0;
    logic            [7:0] ext_val = 8'h00;
    logic            [7:0] clamp_low = 8'h00;
    logic            [7:0] rdata, held, a_pin, b_pin, d_out, a_out, b_out;
    logic            [7:0] a_oe_n, b_oe_n;
    logic                  d_oe_n, cao, cao_n, cbo, cbo_n, cap, cbp;
    int                    failures = 0;
    int                    compares = 0;

    always #12.5 clk = ~clk;

    dpio_top uut (.clk(clk), .rstn(rstn), .bus_phase_clock(bus.phase),
        .chip_sel(sel), .bus_read(bus.read), .reg_select_high(bus.rs[1]),
        .reg_select_low(bus.rs[0]), .data_in(bus.data), .data_out(d_out),
        .data_oe_n(d_oe_n), .port_a_lines_in(a_pin),
        .port_a_lines_out(a_out), .port_a_lines_oe_n(a_oe_n),
        .port_b_lines_in(b_pin), .port_b_lines_out(b_out),
        .port_b_lines_oe_n(b_oe_n), .port_a_ctrl_in(a_ctl),
        .port_b_ctrl_in(b_ctl), .port_a_ctrl_io_in(cap),
        .port_a_ctrl_io_out(cao), .port_a_ctrl_io_oe_n(cao_n),
        .port_b_ctrl_io_in(cbp), .port_b_ctrl_io_out(cbo),
        .port_b_ctrl_io_oe_n(cbo_n));

    dpio_periph_model peer (.a_out(a_out), .a_oe_n(a_oe_n), .b_out(b_out),
        .b_oe_n(b_oe_n), .ext_val(ext_val), .clamp_low(clamp_low),
        .cio_a_out(cao), .cio_a_oe_n(cao_n), .cio_b_out(cbo),
        .cio_b_oe_n(cbo_n), .a_pins(a_pin), .b_pins(b_pin),
        .cio_a_pins(cap), .cio_b_pins(cbp));

    task automatic chk(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One bus cycle; read data and port A outputs captured before phase falls
    task automatic bus_op(input logic rd, input logic [1:0] rs,
                          input logic [7:0] d);
        @(negedge clk);
        bus.phase = 1'b1;
        sel = 1'b1;
        bus.read = rd;
        bus.rs = rs;
        bus.data = d;
        repeat (5) @(negedge clk);
        rdata = d_out;
        held = a_out;
        if (rd) chk("data_oe_n", 8'h00, {7'h00, d_oe_n});
        bus.phase = 1'b0;
        repeat (6) @(negedge clk);
        sel = 1'b0;
    endtask

    task automatic rd(input logic [1:0] rs, input logic [7:0] exp,
                      input string name);
        bus_op(1'b1, rs, 8'h00);
        chk(name, exp, rdata);
    endtask

    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        print_verdict();
    end

    initial begin
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        chk("a_oe_n reset", 8'hff, a_oe_n);
        chk("b_oe_n reset", 8'hff, b_oe_n);
        chk("a_out reset", 8'h00, a_out);
        rd(dpio_pkg::RS_CTRL_A, 8'h00, "ctrl a reset");
        rd(dpio_pkg::RS_PORT_B, 8'h00, "dir b reset");
        bus_op(1'b0, dpio_pkg::RS_PORT_A, 8'hf0);
        rd(dpio_pkg::RS_PORT_A, 8'hf0, "dir a");
        chk("a_oe_n", 8'h0f, a_oe_n);
        bus_op(1'b0, dpio_pkg::RS_CTRL_A, 8'h04);
        rd(dpio_pkg::RS_CTRL_A, 8'h04, "ctrl a");
        bus_op(1'b0, dpio_pkg::RS_PORT_A, 8'ha5);
        chk("a_out held", 8'h00, held);
        chk("a_out", 8'ha5, a_out);
        ext_val = 8'h3c;
        clamp_low = 8'h80;
        rd(dpio_pkg::RS_PORT_A, 8'h2c, "pins a");
        chk("port a in bits", 8'h0c, rdata & ~8'hf0);
        bus_op(1'b0, dpio_pkg::RS_PORT_B, 8'h0f);
        bus_op(1'b0, dpio_pkg::RS_CTRL_B, 8'h04);
        bus_op(1'b0, dpio_pkg::RS_PORT_B, 8'h5a);
        chk("b_out", 8'h5a, b_out);
        clamp_low = 8'hff;
        ext_val = 8'ha3;
        chk("b_oe_n", 8'hf0, b_oe_n);
        rd(dpio_pkg::RS_PORT_B, 8'haa, "mix b");
        rd(dpio_pkg::RS_CTRL_B, 8'h04, "ctrl b");
        // Port B handshake: low on latch write, high on control input rise
        bus_op(1'b0, dpio_pkg::RS_CTRL_B, 8'h26);
        chk("ctrl b io idle", 8'h01, {7'h00, cbo});
        chk("ctrl b io oe_n", 8'h00, {7'h00, cbo_n});
        bus_op(1'b0, dpio_pkg::RS_PORT_B, 8'h3c);
        chk("ctrl b io write", 8'h00, {7'h00, cbo});
        b_ctl = 1'b1;
        repeat (4) @(negedge clk);
        chk("ctrl b io done", 8'h01, {7'h00, cbo});
        rd(dpio_pkg::RS_CTRL_B, 8'ha6, "ctrl b flag");
        bus_op(1'b0, dpio_pkg::RS_CTRL_A, 8'h06);
        @(negedge clk);
        a_ctl = 1'b1;
        repeat (4) @(negedge clk);
        rd(dpio_pkg::RS_CTRL_A, 8'h86, "flag set");
        bus_op(1'b1, dpio_pkg::RS_PORT_A, 8'h00);
        rd(dpio_pkg::RS_CTRL_A, 8'h06, "flag clear");
        bus_op(1'b0, dpio_pkg::RS_CTRL_A, 8'h3c);
        chk("ctrl io high", 8'h01, {7'h00, cao});
        chk("ctrl io oe_n", 8'h00, {7'h00, cao_n});
        bus_op(1'b0, dpio_pkg::RS_CTRL_A, 8'h34);
        chk("ctrl io low", 8'h00, {7'h00, cao});
        // Port A pulse: low from a data read until the next phase fall
        bus_op(1'b0, dpio_pkg::RS_CTRL_A, 8'h2c);
        rd(dpio_pkg::RS_CTRL_A, 8'h2c, "ctrl a pulse");
        chk("ctrl io pulse idle", 8'h01, {7'h00, cao});
        rd(dpio_pkg::RS_PORT_A, 8'h03, "pins a clamped");
        chk("ctrl io pulse", 8'h00, {7'h00, cao});
        rd(dpio_pkg::RS_CTRL_A, 8'h2c, "ctrl a again");
        chk("ctrl io pulse end", 8'h01, {7'h00, cao});
        print_verdict();
    end
endmodule
